// File: sim/ccsc_pin_model.sv
// Far-side model of one timer channel pin and its external capture source
`timescale 1ns/100ps
module ccsc_pin_model
(
	input wire logic pin_o,
	input wire logic pin_oe,
	input wire logic ext_level,
	output logic pin_i
);

	// ****************************************
	// Wire resolution
	// ****************************************
	// The device owns the wire while it drives it; otherwise the outside source does
	assign pin_i = pin_oe ? pin_o : ext_level;

endmodule

// File: sim/tb_top.sv
// Self-checking testbench of the capture/compare status controller
`timescale 1ns/100ps
module tb_top;
	import ccsc_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic [ADDR_W-1:0] AVS_ADDRESS = '0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [DATA_W-1:0] AVS_WRITEDATA = '0;
	logic [3:0] AVS_BYTEENABLE = 4'h0;
	logic [DATA_W-1:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic pin_a, pin_b, a_o, a_oe, b_o, b_oe;
	logic WRAP_IRQ, CHAN_A_IRQ, CHAN_B_IRQ, CHAN_C_IRQ, CHAN_D_IRQ, IRQ;
	logic ext_a = 1'b0;
	logic ext_b = 1'b0;
	logic [31:0] rd = '0;
	logic [31:0] gexp = '0;
	logic [1:0] acts [6] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b11, 2'b00};
	logic pin_exp [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	ccsc_top uut
	(
		.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .CHAN_A_PIN_I(pin_a), .CHAN_A_PIN_O(a_o),
		.CHAN_A_PIN_OE(a_oe), .CHAN_B_PIN_I(pin_b), .CHAN_B_PIN_O(b_o),
		.CHAN_B_PIN_OE(b_oe), .WRAP_IRQ(WRAP_IRQ), .CHAN_A_IRQ(CHAN_A_IRQ),
		.CHAN_B_IRQ(CHAN_B_IRQ), .CHAN_C_IRQ(CHAN_C_IRQ), .CHAN_D_IRQ(CHAN_D_IRQ), .IRQ(IRQ)
	);

	ccsc_pin_model pm_a (.pin_o(a_o), .pin_oe(a_oe), .ext_level(ext_a), .pin_i(pin_a));
	ccsc_pin_model pm_b (.pin_o(b_o), .pin_oe(b_oe), .ext_level(ext_b), .pin_i(pin_b));

	initial
	begin
		forever #50 MCLK = ~MCLK;
	end

	// ****************************************
	// Bus and checking tasks
	// ****************************************
	// Request stands from just after an edge until waitrequest is seen low at a rising edge
	task automatic bus_op(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		AVS_ADDRESS <= {idx, 2'b00};
		AVS_WRITEDATA <= wd;
		AVS_BYTEENABLE <= 4'hF;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do
		begin
			@(posedge MCLK);
			n++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (n >= 20)
			err_count++;
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge MCLK);
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk1(input string name, input logic seen, input logic exp);
		check(name, {31'h0, seen}, {31'h0, exp});
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		bus_op(1'b1, idx, d);
	endtask

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp, input string name);
		bus_op(1'b0, idx, 32'h0000_0000);
		check(name, rd, exp);
	endtask

	task automatic print_verdict();
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************
	// Hang guard
	// ****************************************
	always @(posedge MCLK)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_count++;
			print_verdict();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		rd_chk(IDX_IRQ_EN, 32'h0000_0070, "irq_enable");
		rd_chk(IDX_STATUS, 32'h0000_0070, "status");
		rd_chk(IDX_IO_AB, 32'h0000_0088, "io_control");
		rd_chk(IDX_COUNTER, 32'h0000_0000, "counter");
		rd_chk(IDX_GR_A, 32'h0000_FFFF, "general_reg_a");
		rd_chk(4'hF, 32'h0000_0000, "unmapped");
		wr(IDX_IO_AB, 32'h0000_00FF);
		rd_chk(IDX_IO_AB, 32'h0000_00FF, "io_control");
		wr(IDX_IO_AB, 32'h0000_0000);
		rd_chk(IDX_IO_AB, 32'h0000_0088, "io_control");
		wr(IDX_COUNTER, 32'h0000_1234);
		rd_chk(IDX_COUNTER, 32'h0000_1234, "counter");
		// Wrap past FFFF, where all four general registers also match
		wr(IDX_IRQ_EN, 32'h0000_0080);
		wr(IDX_COUNTER, 32'h0000_FFF0);
		wr(IDX_CTRL, 32'h0000_0001);
		repeat (30) @(posedge MCLK);
		wr(IDX_CTRL, 32'h0000_0000);
		chk1("wrap_irq", WRAP_IRQ, 1'b1);
		chk1("chan_a_irq", CHAN_A_IRQ, 1'b0);
		wr(IDX_STATUS, 32'h0000_0000);
		rd_chk(IDX_STATUS, 32'h0000_00FF, "status");
		wr(IDX_IRQ_EN, 32'h0000_000F);
		chk1("wrap_irq", WRAP_IRQ, 1'b0);
		chk1("chan_a_irq", CHAN_A_IRQ, 1'b1);
		chk1("chan_b_irq", CHAN_B_IRQ, 1'b1);
		chk1("chan_c_irq", CHAN_C_IRQ, 1'b1);
		chk1("chan_d_irq", CHAN_D_IRQ, 1'b1);
		// Status was read as FF above; ones written keep their flags
		wr(IDX_STATUS, 32'h0000_00FE);
		rd_chk(IDX_STATUS, 32'h0000_00FE, "status");
		wr(IDX_STATUS, 32'h0000_0000);
		rd_chk(IDX_STATUS, 32'h0000_0070, "status");
		chk1("irq", IRQ, 1'b0);
		// Compare actions on both pins
		wr(IDX_GR_A, 32'h0000_0105);
		wr(IDX_GR_B, 32'h0000_0105);
		for (int i = 0; i < 6; i++)
		begin
			wr(IDX_IO_AB, {24'h0, 2'b00, acts[i], 2'b00, acts[i]});
			wr(IDX_COUNTER, 32'h0000_0100);
			wr(IDX_CTRL, 32'h0000_0001);
			repeat (10) @(posedge MCLK);
			wr(IDX_CTRL, 32'h0000_0000);
			chk1("pin_a", a_o, pin_exp[i]);
			chk1("pin_b", b_o, pin_exp[i]);
			chk1("pin_a_oe", a_oe, 1'b1);
		end
		rd_chk(IDX_STATUS, 32'h0000_0073, "status");
		wr(IDX_STATUS, 32'h0000_0000);
		rd_chk(IDX_STATUS, 32'h0000_0070, "status");
		// Capture on every edge code, rising then falling
		for (int e = 0; e < 4; e++)
		begin
			wr(IDX_IO_AB, {24'h0, 2'b01, 2'(e), 2'b01, 2'(e)});
			chk1("pin_b_oe", b_oe, 1'b0);
			for (int k = 0; k < 2; k++)
			begin
				wr(IDX_GR_A, 32'h0000_AAAA);
				wr(IDX_GR_B, 32'h0000_AAAA);
				gexp = 32'h0000_0300 + 32'(e * 2 + k);
				wr(IDX_COUNTER, gexp);
				ext_a <= (k == 0);
				ext_b <= (k == 0);
				repeat (3) @(posedge MCLK);
				if (!(e >= 2 || e == k))
					gexp = 32'h0000_AAAA;
				rd_chk(IDX_GR_A, gexp, "general_reg_a");
				rd_chk(IDX_GR_B, gexp, "general_reg_b");
			end
		end
		// Clear write lands in the same cycle as a new compare match on channel A
		wr(IDX_IO_AB, 32'h0000_0000);
		wr(IDX_GR_A, 32'h0000_0403);
		wr(IDX_COUNTER, 32'h0000_0400);
		rd_chk(IDX_STATUS, 32'h0000_0073, "status");
		wr(IDX_CTRL, 32'h0000_0001);
		wr(IDX_STATUS, 32'h0000_0000);
		wr(IDX_CTRL, 32'h0000_0000);
		rd_chk(IDX_STATUS, 32'h0000_0071, "status");
		print_verdict();
	end

endmodule

// File: src/ccsc_chan.sv
// One capture/compare channel: general register, match, capture edge and pin action
`timescale 1ns/100ps
module ccsc_chan
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ccsc_pkg::CNT_W-1:0] count,
	input wire logic func_sel,
	input wire logic [1:0] action,
	input wire logic pin_in,
	input wire logic gr_wr,
	input wire logic [ccsc_pkg::CNT_W-1:0] gr_wdata,
	output logic [ccsc_pkg::CNT_W-1:0] gr,
	output logic event_pulse,
	output logic pin_out,
	output logic pin_oe
);
	import ccsc_pkg::*;

	logic [CNT_W-1:0] gr_reg;
	logic eq_prev_reg;
	logic pin_prev_reg;
	logic pin_out_reg;
	logic eq;
	logic compare_hit;
	logic rise;
	logic fall;
	logic edge_hit;
	logic capture_hit;

	// ****************************************
	// Match and capture detection
	// ****************************************
	assign eq = (count == gr_reg);
	assign compare_hit = ~func_sel & eq & ~eq_prev_reg; // RULE6
	assign rise = pin_in & ~pin_prev_reg;
	assign fall = ~pin_in & pin_prev_reg;
	assign edge_hit = action[EDGE_BOTH_BIT] ? (rise | fall) : ((action == EDGE_FALL) ? fall : rise); // RULE14 RULE15
	assign capture_hit = func_sel & edge_hit; // RULE7

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			eq_prev_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end
		else
		begin
			eq_prev_reg <= eq;
			pin_prev_reg <= pin_in;
		end
	end

	// Capture outranks a software write in the same cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gr_reg <= GR_RST;
		else if (capture_hit)
			gr_reg <= count; // RULE7
		else if (gr_wr)
			gr_reg <= gr_wdata;
	end

	// ****************************************
	// Pin action on compare match
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_out_reg <= PIN_RST;
		else if (compare_hit)
		begin
			case (action)
				ACT_NONE: pin_out_reg <= pin_out_reg; // RULE11 RULE13
				ACT_LOW: pin_out_reg <= 1'b0; // RULE11 RULE13 RULE19
				ACT_HIGH: pin_out_reg <= 1'b1; // RULE11 RULE13 RULE19
				ACT_TOGGLE: pin_out_reg <= ~pin_out_reg; // RULE12
				default: pin_out_reg <= pin_out_reg;
			endcase
		end
	end

	assign gr = gr_reg;
	assign event_pulse = compare_hit | capture_hit;
	assign pin_out = pin_out_reg;
	assign pin_oe = ~func_sel; // RULE9 RULE10

	AST_PIN_LEVEL: assert property (@(posedge clk) disable iff (rst) // RULE11
		compare_hit && (action == ACT_LOW || action == ACT_HIGH) |=> pin_out_reg == $past(action[1]))
		else $error("pin level after match differs from action code");
	AST_PIN_TOGGLE: assert property (@(posedge clk) disable iff (rst) // RULE12
		compare_hit && action == ACT_TOGGLE |=> pin_out_reg != $past(pin_out_reg))
		else $error("pin did not toggle on match");
	AST_EDGE_RISE: assert property (@(posedge clk) disable iff (rst) // RULE14
		func_sel && action == EDGE_RISE && $rose(pin_in) |-> event_pulse)
		else $error("rising edge not captured");
	AST_EDGE_FALL_ONLY: assert property (@(posedge clk) disable iff (rst) // RULE15
		func_sel && action == EDGE_FALL && $rose(pin_in) |-> !event_pulse)
		else $error("rising edge captured in falling mode");
endmodule

// File: src/ccsc_pkg.sv
// Constants, encodings and register map of the capture/compare status controller
package ccsc_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int NUM_CH = 4;

	// ****************************************
	// Register word indexes (byte address = index * 4)
	// ****************************************
	localparam logic [3:0] IDX_IRQ_EN = 4'h0;
	localparam logic [3:0] IDX_STATUS = 4'h1;
	localparam logic [3:0] IDX_IO_AB = 4'h2;
	localparam logic [3:0] IDX_COUNTER = 4'h3;
	localparam logic [3:0] IDX_GR_A = 4'h4;
	localparam logic [3:0] IDX_GR_B = 4'h5;
	localparam logic [3:0] IDX_GR_C = 4'h6;
	localparam logic [3:0] IDX_GR_D = 4'h7;
	localparam logic [3:0] IDX_CTRL = 4'h8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_WRAP = 7;
	localparam int BIT_RUN = 0;
	localparam int IO_A_ACT_LSB = 0;
	localparam int IO_A_FUNC = 2;
	localparam int IO_B_ACT_LSB = 4;
	localparam int IO_B_FUNC = 6;

	// ****************************************
	// Reserved read-as-one masks and writable masks
	// ****************************************
	localparam logic [7:0] IRQ_EN_RSV = 8'h70;
	localparam logic [7:0] STATUS_RSV = 8'h70;
	localparam logic [7:0] IO_AB_RSV = 8'h88;
	localparam logic [7:0] IRQ_EN_WMASK = 8'h8F;
	localparam logic [7:0] IO_AB_WMASK = 8'h77;

	// ****************************************
	// Reset values and counter maximum
	// ****************************************
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam logic [7:0] IO_AB_RST = 8'h00;
	localparam logic [15:0] COUNTER_RST = 16'h0000;
	localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
	localparam logic [15:0] GR_RST = 16'hFFFF;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic PIN_RST = 1'b0;
	localparam logic RUN_RST = 1'b0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// ****************************************
	// Compare output actions and capture edges
	// ****************************************
	localparam logic [1:0] ACT_NONE = 2'b00;
	localparam logic [1:0] ACT_LOW = 2'b01;
	localparam logic [1:0] ACT_HIGH = 2'b10;
	localparam logic [1:0] ACT_TOGGLE = 2'b11;
	localparam logic [1:0] EDGE_RISE = 2'b00;
	localparam logic [1:0] EDGE_FALL = 2'b01;
	localparam int EDGE_BOTH_BIT = 1;

	// ****************************************
	// Bus handshake states
	// ****************************************
	typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ACK} ccsc_bus_t;

endpackage

// File: src/ccsc_top.sv
// Capture/compare status, interrupt enable and channel I/O control with Avalon-MM slave
`timescale 1ns/100ps

// Summary of operation
// RULE1: Overflow interrupt needs enable bit seven and flag.
// RULE2: Each channel has own interrupt, enables bits 3-0.
// RULE3: Enable and status bits 6-4 read as one.
// RULE4: Counter wrap to zero sets overflow flag.
// RULE5: Overflow flag clears after read-one then write-zero.
// RULE6: Compare mode: counter equal register sets flag.
// RULE7: Capture mode: event copies counter, sets flag.
// RULE8: Channel flag clears after read-one then write-zero.
// RULE9: Channel A select: zero compare, one capture.
// RULE10: Channel B select: zero compare, one capture.
// RULE11: Channel A action: none, low, high.
// RULE12: Fourth action code toggles pin on match.
// RULE13: Channel B action: none, low, high.
// RULE14: Channel A capture edge: rise, fall, both.
// RULE15: Channel B capture edge: rise, fall, both.
// RULE16: I/O control bits 7 and 3 read one.
// RULE17: Sixteen-bit readable writable up-counter.
// RULE18: Set beats clear; writing one has no effect.
// RULE19: Matching level already on pin stays.
module ccsc_top
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [ccsc_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [ccsc_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [ccsc_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic CHAN_A_PIN_I,
	output logic CHAN_A_PIN_O,
	output logic CHAN_A_PIN_OE,
	input wire logic CHAN_B_PIN_I,
	output logic CHAN_B_PIN_O,
	output logic CHAN_B_PIN_OE,
	output logic WRAP_IRQ,
	output logic CHAN_A_IRQ,
	output logic CHAN_B_IRQ,
	output logic CHAN_C_IRQ,
	output logic CHAN_D_IRQ,
	output logic IRQ
);
	import ccsc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic sel(input logic strobe, input logic [3:0] idx, input logic [3:0] want);
		return strobe && (idx == want);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0])
			res[7:0] = wd[7:0];
		if (be[1])
			res[15:8] = wd[15:8];
		return res;
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	ccsc_bus_t bus_state_reg;
	ccsc_bus_t bus_state_next;
	logic [DATA_W-1:0] readdata_reg;
	logic [DATA_W-1:0] rd_mux;
	logic [3:0] idx;
	logic req;
	logic wr_now;
	logic rd_now;
	logic lo_byte;
	logic [7:0] irq_en_reg;
	logic [7:0] io_ab_reg;
	logic run_reg;
	logic [CNT_W-1:0] counter_reg;
	logic counter_wr;
	logic wrap_set;
	logic [4:0] flags_reg;
	logic [4:0] flags_next;
	logic [4:0] flags_set;
	logic [4:0] flags_clr;
	logic [4:0] seen_reg;
	logic status_wr;
	logic [4:0] status_rd_bits;
	logic [4:0] written_zero;
	logic [7:0] irq_en_rd;
	logic [7:0] status_rd;
	logic [7:0] io_ab_rd;
	logic [NUM_CH-1:0] ch_func;
	logic [1:0] ch_act [NUM_CH];
	logic [NUM_CH-1:0] ch_pin_in;
	logic [NUM_CH-1:0] ch_pin_out;
	logic [NUM_CH-1:0] ch_pin_oe;
	logic [NUM_CH-1:0] ch_gr_wr;
	logic [CNT_W-1:0] ch_gr [NUM_CH];
	logic [NUM_CH-1:0] ch_hit;

	// ****************************************
	// Avalon-MM handshake
	// ****************************************
	assign req = AVS_READ | AVS_WRITE;
	assign idx = AVS_ADDRESS[5:2];
	assign wr_now = AVS_WRITE && (bus_state_reg == BUS_ACK);
	assign rd_now = AVS_READ && (bus_state_reg == BUS_ACK);
	assign lo_byte = AVS_BYTEENABLE[0];
	assign AVS_WAITREQUEST = req && (bus_state_reg != BUS_ACK);
	assign AVS_READDATA = readdata_reg;

	always_comb
	begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: if (req) bus_state_next = BUS_FETCH;
			BUS_FETCH: bus_state_next = BUS_ACK;
			BUS_ACK: bus_state_next = BUS_IDLE;
			default: bus_state_next = BUS_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			bus_state_reg <= BUS_IDLE;
		else
			bus_state_reg <= bus_state_next;
	end

	// ****************************************
	// Read path
	// ****************************************
	assign irq_en_rd = irq_en_reg | IRQ_EN_RSV; // RULE3
	assign status_rd = {flags_reg[4], 3'b000, flags_reg[3:0]} | STATUS_RSV; // RULE3
	assign io_ab_rd = io_ab_reg | IO_AB_RSV; // RULE16

	always_comb
	begin
		rd_mux = UNMAPPED_DATA;
		case (idx)
			IDX_IRQ_EN: rd_mux[7:0] = irq_en_rd;
			IDX_STATUS: rd_mux[7:0] = status_rd;
			IDX_IO_AB: rd_mux[7:0] = io_ab_rd;
			IDX_COUNTER: rd_mux[15:0] = counter_reg;
			IDX_GR_A: rd_mux[15:0] = ch_gr[0];
			IDX_GR_B: rd_mux[15:0] = ch_gr[1];
			IDX_GR_C: rd_mux[15:0] = ch_gr[2];
			IDX_GR_D: rd_mux[15:0] = ch_gr[3];
			IDX_CTRL: rd_mux[BIT_RUN] = run_reg;
			default: rd_mux = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			readdata_reg <= UNMAPPED_DATA;
		else if (AVS_READ && bus_state_reg == BUS_FETCH)
			readdata_reg <= rd_mux;
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			irq_en_reg <= IRQ_EN_RST;
		else if (sel(wr_now, idx, IDX_IRQ_EN) && lo_byte)
			irq_en_reg <= AVS_WRITEDATA[7:0] & IRQ_EN_WMASK; // RULE1 RULE2
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			io_ab_reg <= IO_AB_RST;
		else if (sel(wr_now, idx, IDX_IO_AB) && lo_byte)
			io_ab_reg <= AVS_WRITEDATA[7:0] & IO_AB_WMASK; // RULE16
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			run_reg <= RUN_RST;
		else if (sel(wr_now, idx, IDX_CTRL) && lo_byte)
			run_reg <= AVS_WRITEDATA[BIT_RUN];
	end

	// ****************************************
	// Up-counter
	// ****************************************
	assign counter_wr = sel(wr_now, idx, IDX_COUNTER);
	assign wrap_set = run_reg && !counter_wr && (counter_reg == COUNTER_MAX); // RULE4

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			counter_reg <= COUNTER_RST;
		else if (counter_wr)
			counter_reg <= merge16(counter_reg, AVS_WRITEDATA, AVS_BYTEENABLE); // RULE17
		else if (run_reg)
			counter_reg <= counter_reg + 16'h0001; // RULE17
	end

	// ****************************************
	// Channels
	// ****************************************
	assign ch_func = {2'b00, io_ab_reg[IO_B_FUNC], io_ab_reg[IO_A_FUNC]}; // RULE9 RULE10
	assign ch_act[0] = io_ab_reg[IO_A_ACT_LSB +: 2]; // RULE11 RULE14
	assign ch_act[1] = io_ab_reg[IO_B_ACT_LSB +: 2]; // RULE13 RULE15
	assign ch_act[2] = ACT_NONE;
	assign ch_act[3] = ACT_NONE;
	assign ch_pin_in = {2'b00, CHAN_B_PIN_I, CHAN_A_PIN_I};

	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_chan
		assign ch_gr_wr[i] = sel(wr_now, idx, IDX_GR_A + 4'(i));
		ccsc_chan u_chan
		(
			.clk(MCLK),
			.rst(RST),
			.count(counter_reg),
			.func_sel(ch_func[i]),
			.action(ch_act[i]),
			.pin_in(ch_pin_in[i]),
			.gr_wr(ch_gr_wr[i]),
			.gr_wdata(merge16(ch_gr[i], AVS_WRITEDATA, AVS_BYTEENABLE)),
			.gr(ch_gr[i]),
			.event_pulse(ch_hit[i]),
			.pin_out(ch_pin_out[i]),
			.pin_oe(ch_pin_oe[i])
		);
	end

	assign CHAN_A_PIN_O = ch_pin_out[0];
	assign CHAN_A_PIN_OE = ch_pin_oe[0];
	assign CHAN_B_PIN_O = ch_pin_out[1];
	assign CHAN_B_PIN_OE = ch_pin_oe[1];

	// ****************************************
	// Status flags: read as one, then write zero
	// ****************************************
	assign status_wr = sel(wr_now, idx, IDX_STATUS) && lo_byte;
	assign status_rd_bits = {readdata_reg[BIT_WRAP], readdata_reg[3:0]};
	assign written_zero = ~{AVS_WRITEDATA[BIT_WRAP], AVS_WRITEDATA[3:0]};
	assign flags_set = {wrap_set, ch_hit}; // RULE4 RULE6 RULE7
	assign flags_clr = status_wr ? (written_zero & seen_reg) : 5'h00; // RULE5 RULE8
	assign flags_next = (flags_reg & ~flags_clr) | flags_set; // RULE18

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			flags_reg <= FLAGS_RST;
		else
			flags_reg <= flags_next;
	end

	// Arming is dropped by any status write with byte 0 enabled, so each clear needs a fresh read
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			seen_reg <= FLAGS_RST;
		else if (status_wr)
			seen_reg <= FLAGS_RST;
		else if (sel(rd_now, idx, IDX_STATUS))
			seen_reg <= seen_reg | status_rd_bits; // RULE5 RULE8
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign WRAP_IRQ = flags_reg[4] & irq_en_reg[BIT_WRAP]; // RULE1
	assign CHAN_A_IRQ = flags_reg[0] & irq_en_reg[0]; // RULE2
	assign CHAN_B_IRQ = flags_reg[1] & irq_en_reg[1]; // RULE2
	assign CHAN_C_IRQ = flags_reg[2] & irq_en_reg[2]; // RULE2
	assign CHAN_D_IRQ = flags_reg[3] & irq_en_reg[3]; // RULE2
	assign IRQ = WRAP_IRQ | CHAN_A_IRQ | CHAN_B_IRQ | CHAN_C_IRQ | CHAN_D_IRQ;

	// ****************************************
	// Assertions
	// ****************************************
	AST_WRAP_IRQ: assert property (@(posedge MCLK) disable iff (RST) // RULE1
		$rose(flags_reg[4]) && irq_en_reg[BIT_WRAP] |-> IRQ && WRAP_IRQ)
		else $error("enabled wrap flag gave no interrupt");
	AST_WRAP_MASKED: assert property (@(posedge MCLK) disable iff (RST) // RULE1
		!irq_en_reg[BIT_WRAP] |-> !WRAP_IRQ)
		else $error("wrap interrupt while disabled");
	AST_CHAN_IRQ: assert property (@(posedge MCLK) disable iff (RST) // RULE2
		ch_hit[1] && irq_en_reg[1] |=> CHAN_B_IRQ && IRQ)
		else $error("channel B event gave no interrupt");
	AST_RSV_READ: assert property (@(posedge MCLK) disable iff (RST) // RULE3
		rd_now && (idx == IDX_IRQ_EN || idx == IDX_STATUS) |-> AVS_READDATA[6:4] == 3'b111)
		else $error("reserved bits did not read one");
	AST_WRAP_SET: assert property (@(posedge MCLK) disable iff (RST) // RULE4
		run_reg && !counter_wr && counter_reg == COUNTER_MAX |=> flags_reg[4] && counter_reg == COUNTER_RST)
		else $error("wrap did not set flag");
	AST_WRAP_CLEAR: assert property (@(posedge MCLK) disable iff (RST) // RULE5
		$fell(flags_reg[4]) |-> $past(seen_reg[4]) && $past(status_wr) && !$past(AVS_WRITEDATA[BIT_WRAP]))
		else $error("wrap flag cleared without read-then-write-zero");
	AST_CMP_FLAG: assert property (@(posedge MCLK) disable iff (RST) // RULE6
		!ch_func[0] && counter_reg == ch_gr[0] && !$past(counter_reg == ch_gr[0]) |=> flags_reg[0])
		else $error("compare match did not set flag A");
	AST_CAPTURE: assert property (@(posedge MCLK) disable iff (RST) // RULE7
		ch_func[1] && ch_hit[1] |=> ch_gr[1] == $past(counter_reg) && flags_reg[1])
		else $error("capture did not load counter");
	AST_CHAN_CLEAR: assert property (@(posedge MCLK) disable iff (RST) // RULE8
		$fell(flags_reg[0]) |-> $past(seen_reg[0]) && $past(status_wr))
		else $error("channel flag cleared without read-then-write-zero");
	AST_FUNC_A: assert property (@(posedge MCLK) disable iff (RST) // RULE9
		io_ab_reg[IO_A_FUNC] |-> !CHAN_A_PIN_OE)
		else $error("pin A driven in capture mode");
	AST_FUNC_B: assert property (@(posedge MCLK) disable iff (RST) // RULE10
		!io_ab_reg[IO_B_FUNC] |-> CHAN_B_PIN_OE)
		else $error("pin B not driven in compare mode");
	AST_IO_RSV: assert property (@(posedge MCLK) disable iff (RST) // RULE16
		rd_now && idx == IDX_IO_AB |-> AVS_READDATA[7] && AVS_READDATA[3])
		else $error("I/O control reserved bits did not read one");
	AST_COUNT_UP: assert property (@(posedge MCLK) disable iff (RST) // RULE17
		run_reg && !counter_wr |=> counter_reg == 16'($past(counter_reg) + 16'h0001))
		else $error("counter did not increment");
	AST_SET_WINS: assert property (@(posedge MCLK) disable iff (RST) // RULE18
		status_wr && ch_hit[0] |=> flags_reg[0])
		else $error("clear beat a simultaneous set");
	AST_WRITE_ONE: assert property (@(posedge MCLK) disable iff (RST) // RULE18
		status_wr && AVS_WRITEDATA[0] && flags_reg[0] |=> flags_reg[0])
		else $error("writing one cleared a flag");
	AST_BUS_ANSWER: assert property (@(posedge MCLK) disable iff (RST)
		req && bus_state_reg == BUS_IDLE |=> ##1 !AVS_WAITREQUEST)
		else $error("bus answer not on third cycle");
endmodule
